// File: pkg/quad_dac_pkg.sv
package quad_dac_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_CH = 4;
  localparam int DATA_W = 10;
  localparam int PD_W = 2;
  localparam int WORD_W = 12;

  // ****************************************
  // Command byte field positions
  // ****************************************
  localparam int EXT_ADDR_HI_POS = 7;
  localparam int EXT_ADDR_LO_POS = 6;
  localparam int UPDATE_MODE_HI_POS = 5;
  localparam int UPDATE_MODE_LO_POS = 4;
  localparam int CHAN_PICK_HI_POS = 2;
  localparam int CHAN_PICK_LO_POS = 1;
  localparam int PD_FLAG_POS = 0;

  // ****************************************
  // Data byte field positions
  // ****************************************
  localparam int PD_CODE_HI_POS = 7;
  localparam int PD_CODE_LO_POS = 6;
  localparam int LOWER_BIT1_POS = 7;
  localparam int LOWER_BIT0_POS = 6;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 10'h000;
  localparam logic [PD_W-1:0] PD_NONE = 2'h0;

  // ****************************************
  // Update modes
  // ****************************************
  typedef enum logic [1:0] {
    MODE_STAGE_ONLY = 2'h0,
    MODE_STAGE_LOAD_ONE = 2'h1,
    MODE_STAGE_LOAD_ALL = 2'h2,
    MODE_BROADCAST = 2'h3
  } update_mode_t;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [PD_W-1:0] pd_code;
    logic [DATA_W-1:0] data;
  } chan_word_t;

  typedef chan_word_t [NUM_CH-1:0] chan_set_t;

  typedef struct packed {
    logic [7:0] command;
    logic [7:0] upper;
    logic [7:0] lower;
  } frame_word_t;

  localparam chan_word_t CHAN_WORD_RST = '{pd_code: PD_NONE, data: DATA_ZERO};
  localparam frame_word_t FRAME_WORD_RST = '{command: BYTE_RST, upper: BYTE_RST, lower: BYTE_RST};

endpackage : quad_dac_pkg

// File: design/quad_dac_update_control.sv
`timescale 1ns/1ps

module quad_dac_update_control
  import quad_dac_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic link_clk_i,
  input wire logic frame_begin_i,
  input wire logic frame_end_i,
  input wire logic byte_done_i,
  input wire logic [7:0] byte_i,
  input wire logic ext_addr_hi_i,
  input wire logic ext_addr_lo_i,
  input wire logic async_load_pin_i,
  output logic [7:0] command_byte_o,
  output chan_set_t staging_o,
  output chan_set_t output_code_o,
  output logic update_done_o
);

  // ****************************************
  // Link side byte sequencer
  // ****************************************
  typedef enum logic [4:0] {
    LINK_IDLE = 5'h01,
    LINK_COMMAND = 5'h02,
    LINK_UPPER = 5'h04,
    LINK_LOWER = 5'h08,
    LINK_HOLD = 5'h10
  } link_state_t;

  link_state_t link_state_q;
  link_state_t link_state_d;
  logic [7:0] link_command_q;
  logic [7:0] link_upper_q;
  frame_word_t link_word_q;
  logic link_toggle_q;
  logic lower_taken;

  assign lower_taken = byte_done_i && (link_state_q == LINK_LOWER);

  always_comb begin
    link_state_d = link_state_q;
    unique case (link_state_q)
      LINK_IDLE: begin
        link_state_d = LINK_IDLE;
      end
      LINK_COMMAND: begin
        if (byte_done_i) begin
          link_state_d = LINK_UPPER;
        end
      end
      LINK_UPPER: begin
        if (byte_done_i) begin
          link_state_d = LINK_LOWER;
        end
      end
      LINK_LOWER: begin
        if (byte_done_i) begin
          if (link_command_q[PD_FLAG_POS]) begin
            link_state_d = LINK_HOLD;
          end else begin
            link_state_d = LINK_UPPER;
          end
        end
      end
      LINK_HOLD: begin
        link_state_d = LINK_HOLD;
      end
      default: begin
        link_state_d = LINK_IDLE;
      end
    endcase
    // Frame end or restart drops any partial word
    if (frame_end_i) begin
      link_state_d = LINK_IDLE;
    end
    if (frame_begin_i) begin
      link_state_d = LINK_COMMAND;
    end
  end

  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_state_q <= LINK_IDLE;
    end else begin
      link_state_q <= link_state_d;
    end
  end

  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_command_q <= BYTE_RST;
    end else if (byte_done_i && (link_state_q == LINK_COMMAND)) begin
      link_command_q <= byte_i;
    end
  end

  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_upper_q <= BYTE_RST;
    end else if (byte_done_i && (link_state_q == LINK_UPPER)) begin
      link_upper_q <= byte_i;
    end
  end

  // Word stays stable until the next lower byte
  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_word_q <= FRAME_WORD_RST;
    end else if (lower_taken) begin
      link_word_q.command <= link_command_q;
      link_word_q.upper <= link_upper_q;
      link_word_q.lower <= byte_i;
    end
  end

  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_toggle_q <= 1'b0;
    end else if (lower_taken) begin
      link_toggle_q <= ~link_toggle_q;
    end
  end

  // ****************************************
  // Crossings into the system clock
  // ****************************************
  logic toggle_meta_q;
  logic toggle_sync_q;
  logic toggle_seen_q;
  logic load_meta_q;
  logic load_sync_q;
  logic load_prev_q;
  logic [1:0] addr_meta_q;
  logic [1:0] addr_sync_q;
  logic toggle_edge;
  logic serial_event;
  logic load_rise;
  logic event_q;
  frame_word_t word_hold_q;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      toggle_meta_q <= 1'b0;
      toggle_sync_q <= 1'b0;
      toggle_seen_q <= 1'b0;
    end else begin
      toggle_meta_q <= link_toggle_q;
      toggle_sync_q <= toggle_meta_q;
      toggle_seen_q <= toggle_sync_q;
    end
  end

  // Pin is asynchronous; two stages before edge detect
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      load_meta_q <= 1'b0;
      load_sync_q <= 1'b0;
      load_prev_q <= 1'b0;
    end else begin
      load_meta_q <= async_load_pin_i;
      load_sync_q <= load_meta_q;
      load_prev_q <= load_sync_q;
    end
  end

  // Extended address pins are levels from outside
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_meta_q <= 2'h0;
      addr_sync_q <= 2'h0;
    end else begin
      addr_meta_q <= {ext_addr_hi_i, ext_addr_lo_i};
      addr_sync_q <= addr_meta_q;
    end
  end

  // One flip of the link toggle per taken lower byte
  assign toggle_edge = toggle_sync_q ^ toggle_seen_q;
  assign serial_event = event_q;
  assign load_rise = load_sync_q && !load_prev_q;

  // ****************************************
  // Word capture into the system clock
  // ****************************************
  // Link word changes on the same edge as a toggle flip, then stays quiet for many cycles
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      word_hold_q <= FRAME_WORD_RST;
    end else if (toggle_edge) begin
      word_hold_q <= link_word_q;
    end
  end

  // Event lines up with the captured word
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      event_q <= 1'b0;
    end else begin
      event_q <= toggle_edge;
    end
  end

  // ****************************************
  // Decode of the received word
  // ****************************************
  logic [7:0] cmd;
  update_mode_t mode;
  logic [1:0] pick;
  logic pd_flag;
  logic addr_match;
  chan_word_t new_word;

  assign cmd = word_hold_q.command;
  assign mode = update_mode_t'({cmd[UPDATE_MODE_HI_POS], cmd[UPDATE_MODE_LO_POS]});
  assign pick = {cmd[CHAN_PICK_HI_POS], cmd[CHAN_PICK_LO_POS]};
  assign pd_flag = cmd[PD_FLAG_POS];
  assign addr_match = ({cmd[EXT_ADDR_HI_POS], cmd[EXT_ADDR_LO_POS]} == addr_sync_q);

  always_comb begin
    if (pd_flag) begin
      // Powerdown word carries no conversion data
      new_word.pd_code = {word_hold_q.upper[PD_CODE_HI_POS], word_hold_q.upper[PD_CODE_LO_POS]};
      new_word.data = DATA_ZERO;
    end else begin
      new_word.pd_code = PD_NONE;
      new_word.data = {word_hold_q.upper,
                       word_hold_q.lower[LOWER_BIT1_POS], word_hold_q.lower[LOWER_BIT0_POS]};
    end
  end

  // ****************************************
  // Register update
  // ****************************************
  chan_set_t staging_q;
  chan_set_t staging_d;
  chan_set_t output_q;
  chan_set_t output_d;
  logic [7:0] command_q;

  always_comb begin
    staging_d = staging_q;
    output_d = output_q;
    if (serial_event) begin
      unique case (mode)
        MODE_STAGE_ONLY: begin
          if (addr_match) begin
            staging_d[pick] = new_word;
          end
        end
        MODE_STAGE_LOAD_ONE: begin
          if (addr_match) begin
            staging_d[pick] = new_word;
            output_d[pick] = new_word;
          end
        end
        MODE_STAGE_LOAD_ALL: begin
          if (addr_match) begin
            staging_d[pick] = new_word;
            // All outputs load from staging including this word
            output_d = staging_d;
          end
        end
        MODE_BROADCAST: begin
          if (!cmd[CHAN_PICK_HI_POS]) begin
            // Staging as it stood before this event
            output_d = staging_q;
          end else begin
            for (int i = 0; i < NUM_CH; i++) begin
              output_d[i] = new_word;
            end
          end
        end
      endcase
    end
    // Load copy sees this cycle's serial write
    if (load_rise) begin
      output_d = staging_d;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      staging_q <= {NUM_CH{CHAN_WORD_RST}};
    end else begin
      staging_q <= staging_d;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      output_q <= {NUM_CH{CHAN_WORD_RST}};
    end else begin
      output_q <= output_d;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      command_q <= BYTE_RST;
    end else if (serial_event) begin
      command_q <= cmd;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      update_done_o <= 1'b0;
    end else begin
      update_done_o <= serial_event || load_rise;
    end
  end

  assign staging_o = staging_q;
  assign output_code_o = output_q;
  assign command_byte_o = command_q;

endmodule : quad_dac_update_control

// File: testbench/quad_dac_chk.sv
`timescale 1ns/1ps
module quad_dac_chk
  import quad_dac_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ext_addr_hi_i,
  input wire logic ext_addr_lo_i,
  input wire logic async_load_pin_i,
  input wire logic [7:0] command_byte_o,
  input wire chan_set_t staging_o,
  input wire chan_set_t output_code_o,
  input wire logic update_done_o
);
  // ****************************************
  // Port checks
  // ****************************************
  logic pd_ok;
  always_comb begin
    pd_ok = 1'b1;
    for (int i = 0; i < NUM_CH; i++) begin
      if (output_code_o[i].pd_code != PD_NONE && output_code_o[i].data != DATA_ZERO) pd_ok = 1'b0;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  sequence pin_rise_s;
    $rose(async_load_pin_i) ##1 async_load_pin_i;
  endsequence
  logic [1:0] pick;
  assign pick = command_byte_o[2:1];
  sequence cmd_s(logic [1:0] m);
    $changed(command_byte_o) && command_byte_o[5:4] == m && command_byte_o[7:6] == {ext_addr_hi_i, ext_addr_lo_i};
  endsequence
  reset_zero_a: assert property ($rose(rstn_i) |-> staging_o == '0 && output_code_o == '0)
    else $error("state not clear after reset");
  stage_done_a: assert property ($changed(staging_o) |-> update_done_o)
    else $error("staging change without done pulse");
  out_done_a: assert property ($changed(output_code_o) |-> update_done_o)
    else $error("output change without done pulse");
  load_copy_a: assert property (pin_rise_s |-> ##[1:5] output_code_o == staging_o)
    else $error("load pin did not copy staging");
  mode0_hold_a: assert property (cmd_s(2'h0) |-> $stable(output_code_o))
    else $error("stage only write moved outputs");
  mode1_copy_a: assert property (cmd_s(2'h1) |-> output_code_o[pick] == staging_o[pick])
    else $error("single load mismatch");
  mode2_all_a: assert property (cmd_s(2'h2) |-> output_code_o == staging_o)
    else $error("load all mismatch");
  pd_data_a: assert property (pd_ok)
    else $error("powerdown word carries data");
endmodule : quad_dac_chk

bind quad_dac_update_control quad_dac_chk chk (.clock_i(clock_i), .rstn_i(rstn_i), .ext_addr_hi_i(ext_addr_hi_i),
  .ext_addr_lo_i(ext_addr_lo_i), .async_load_pin_i(async_load_pin_i), .command_byte_o(command_byte_o),
  .staging_o(staging_o), .output_code_o(output_code_o), .update_done_o(update_done_o));

// File: testbench/link_master_model.sv
`timescale 1ns/1ps
module link_master_model (
  output logic link_clk_o,
  output logic frame_begin_o,
  output logic frame_end_o,
  output logic byte_done_o,
  output logic [7:0] byte_o
);
  // ****************************************
  // Gated link clock and byte frames
  // ****************************************
  logic run;
  initial begin
    {run, link_clk_o, frame_begin_o, frame_end_o, byte_done_o, byte_o} = '0;
    #7;
    forever #40 link_clk_o = run ? ~link_clk_o : 1'b0;
  end
  task automatic frame(input logic [7:0] q[$]);
    run = 1'b1;
    @(posedge link_clk_o) frame_begin_o <= 1'b1;
    @(posedge link_clk_o) frame_begin_o <= 1'b0;
    foreach (q[i]) begin
      @(posedge link_clk_o) byte_done_o <= 1'b1;
      byte_o <= q[i];
      @(posedge link_clk_o) byte_done_o <= 1'b0;
      byte_o <= ~q[i];
    end
    @(posedge link_clk_o) frame_end_o <= 1'b1;
    @(posedge link_clk_o) frame_end_o <= 1'b0;
    repeat (2) @(posedge link_clk_o);
    run = 1'b0;
  endtask : frame
endmodule : link_master_model

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import quad_dac_pkg::*;
  // ****************************************
  // Bench
  // ****************************************
  logic clock_i = 1'b0;
  logic rstn_i = 1'b1;
  logic ahi = 1'b0;
  logic alo = 1'b0;
  logic pin = 1'b0;
  logic link_clk, fb, fe, bd, done_o;
  logic [7:0] lb, cmd_o, last_cmd;
  chan_set_t stg_o, out_o, stg, out;
  logic [31:0] seed = 32'h0000B01A;
  int fails = 0;
  int n_tests = 0;
  int n_done = 0;
  int n_exp = 0;
  int cyc = 0;
  always #10 clock_i = ~clock_i;
  link_master_model m (.link_clk_o(link_clk), .frame_begin_o(fb), .frame_end_o(fe), .byte_done_o(bd),
    .byte_o(lb));
  quad_dac_update_control uut (.clock_i(clock_i), .rstn_i(rstn_i), .link_clk_i(link_clk), .frame_begin_i(fb),
    .frame_end_i(fe), .byte_done_i(bd), .byte_i(lb), .ext_addr_hi_i(ahi), .ext_addr_lo_i(alo),
    .async_load_pin_i(pin), .command_byte_o(cmd_o), .staging_o(stg_o), .output_code_o(out_o),
    .update_done_o(done_o));
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clock_i) begin
    cyc++;
    if (done_o === 1'b1) n_done++;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check_set(input chan_set_t e, input chan_set_t a);
    n_tests++;
    if (a !== e) begin
      fails++;
      $display("unexpected at %0t: channels %h, wanted %h", $time, a, e);
    end
  endtask : check_set
  task automatic check_byte(input logic [7:0] e, input logic [7:0] a);
    n_tests++;
    if (a !== e) begin
      fails++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, a, e);
    end
  endtask : check_byte
  task automatic apply(input logic [7:0] c, input logic [7:0] hi, input logic [7:0] lo);
    chan_word_t w;
    w = c[0] ? {hi[7:6], DATA_ZERO} : {PD_NONE, hi, lo[7:6]};
    last_cmd = c;
    if (c[5:4] != 2'h3 && c[7:6] != {ahi, alo}) return;
    case (c[5:4])
      2'h0: stg[c[2:1]] = w;
      2'h1: begin
        stg[c[2:1]] = w;
        out[c[2:1]] = w;
      end
      2'h2: begin
        stg[c[2:1]] = w;
        out = stg;
      end
      default: out = c[2] ? {NUM_CH{w}} : stg;
    endcase
  endtask : apply
  task automatic wait_done();
    for (int i = 0; i < 400 && n_done < n_exp; i++) @(posedge clock_i);
    @(posedge clock_i);
  endtask : wait_done
  initial begin
    logic [7:0] q[$];
    logic [31:0] r;
    logic [7:0] c;
    int np;
    rstn_i <= 1'b0;
    stg = '0;
    out = '0;
    last_cmd = 8'h00;
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    check_set('0, stg_o);
    check_set('0, out_o);
    for (int k = 0; k < 20; k++) begin
      r = rnd();
      @(posedge clock_i) {ahi, alo} <= r[10:9];
      @(posedge clock_i);
      c = {r[10:9], k[1:0], r[3], k[3], r[1], k[2]};
      if (k == 17) c[7:6] = ~c[7:6];
      np = 1 + r[8];
      q = {c};
      for (int j = 0; j < np; j++) begin
        r = rnd();
        q.push_back(r[7:0]);
        q.push_back(r[15:8]);
        if (j == 0 || !c[0]) apply(c, r[7:0], r[15:8]);
        if (j == 0 || !c[0]) n_exp++;
      end
      m.frame(q);
      wait_done();
      check_set(stg, stg_o);
      check_set(out, out_o);
      check_byte(last_cmd, cmd_o);
      check_byte(n_exp[7:0], n_done[7:0]);
      $display("test %0d done", k);
    end
    c = {ahi, alo, 6'h06};
    apply(c, 8'hA5, 8'hC0);
    n_exp++;
    m.frame({c, 8'hA5, 8'hC0});
    wait_done();
    @(posedge clock_i) pin <= 1'b1;
    repeat (5) @(posedge clock_i);
    pin <= 1'b0;
    out = stg;
    n_exp++;
    wait_done();
    check_set(out, out_o);
    $display("test load pin done");
    report_and_stop();
  end
endmodule : testbench
